// ### osfl_pkg.sv
// shared constants and types for the octal switch fault logic
package osfl_pkg;
  localparam int unsigned NCH        = 8;
  localparam int unsigned WORD_W     = 8;
  localparam int unsigned CLK_KHZ    = 25_000;
  // open-load filter time, inside the 100 us to 300 us window
  localparam int unsigned FILTER_US  = 200;
  localparam int unsigned FILTER_CYC = (FILTER_US * CLK_KHZ + 999) / 1000;
  // least gap the controller leaves between command writes
  localparam int unsigned CMD_GAP_US  = 300;
  localparam int unsigned CMD_GAP_CYC = (CMD_GAP_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned TIMER_W    = 13;
  localparam int unsigned BITCNT_W   = 4;
  localparam logic [3:0]  BITCNT_FULL = 4'h8;
  localparam logic [7:0]  CMD_RST    = 8'h00;
  localparam logic [7:0]  FAULT_RST  = 8'h00;
  // layout of the synchroniser vector
  localparam int unsigned SYNC_W     = 3 + 3 * NCH + 2;
  localparam int unsigned SY_CS      = 0;
  localparam int unsigned SY_SCLK    = 1;
  localparam int unsigned SY_SI      = 2;
  localparam int unsigned SY_OL      = 3;
  localparam int unsigned SY_OT      = SY_OL + NCH;
  localparam int unsigned SY_OC      = SY_OT + NCH;
  localparam int unsigned SY_LUV     = SY_OC + NCH;
  localparam int unsigned SY_PUV     = SY_LUV + 1;
  typedef enum logic [1:0] {
    FILT_BLANK = 2'b01,
    FILT_ARMED = 2'b10
  } osfl_filt_t;
endpackage : osfl_pkg

// ### osfl_sync.sv
// two-flop synchroniser for a vector of unrelated levels
module osfl_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : osfl_sync

// ### osfl_shift.sv
// serial link shift register, mode 0, sampled on the system clock
module osfl_shift (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       clear,
  // synchronised link levels
  input  wire logic       cs_n_s,
  input  wire logic       sclk_s,
  input  wire logic       si_s,
  // word to send
  input  wire logic [7:0] tx_word,
  // results
  output logic      [7:0] rx_word,
  output logic            so_q,
  output logic            so_oe_q,
  output logic            frame_start,
  output logic            frame_end,
  output logic            frame_full
);
  logic                            cs_n_q;
  logic                            sclk_q;
  logic                            in_bit_q;
  logic [7:0]                      shift_q;
  logic [osfl_pkg::BITCNT_W-1:0]   cnt_q;
  logic                            rise;
  logic                            fall;

  assign frame_start = cs_n_q && !cs_n_s;
  assign frame_end   = !cs_n_q && cs_n_s;
  assign rise        = !cs_n_s && !sclk_q && sclk_s;
  assign fall        = !cs_n_s && sclk_q && !sclk_s;
  assign frame_full  = (cnt_q >= osfl_pkg::BITCNT_FULL);
  assign rx_word     = shift_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_s;
      sclk_q <= sclk_s;
    end
  end

  // msb first both ways; longer frames keep the last eight bits
  always_ff @(posedge sys_clk) begin
    if (!nrst || clear) begin
      shift_q  <= osfl_pkg::FAULT_RST;
      in_bit_q <= 1'b0;
      cnt_q    <= '0;
    end else if (frame_start) begin
      shift_q <= tx_word;
      cnt_q   <= '0;
    end else begin
      if (rise) begin
        in_bit_q <= si_s;
      end
      if (fall) begin
        shift_q <= {shift_q[6:0], in_bit_q};
        if (!frame_full) begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst || clear) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_q    <= frame_start ? tx_word[7] : shift_q[7];
      so_oe_q <= !cs_n_s;
    end
  end
endmodule : osfl_shift

// ### osfl_top.sv
// fault detection, filtering and latching for an eight channel switch
// Summary of operation
// (R01) eight bit words, msb first, bit7 channel eight
// (R02) one means on, one means faulted
// (R03) command byte applied at chip select rise
// (R04) controller waits over 300 us between writes
// (R05) open load judged only while commanded off
// (R06) separate open load comparator per channel
// (R07) open load when drain voltage below threshold
// (R08) filter delay suppresses switching transient faults
// (R09) chip select rise restarts the fault timer
// (R10) comparator ignored until the timer expires
// (R11) detected open load latched for readout
// (R12) detect current sources off without logic supply
// (R13) thermal limit shuts only the hot channel
// (R14) cooled channel turns back on alone
// (R15) retry repeats until cleared or commanded off
// (R16) logic undervoltage: outputs off, faults cleared
// (R17) logic supply back: fault updating resumes
// (R18) load undervoltage leaves outputs following command
// (R19) faults below 9 V load supply are suspect
// (R20) latched fault held until shifted out
module osfl_top #(
  parameter int unsigned FILTER_CYCLES = osfl_pkg::FILTER_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // serial link from the controller
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_si,
  output logic            spi_so,
  output logic            spi_so_oe,
  // per channel sensing
  input  wire logic [7:0] ol_below_threshold,
  input  wire logic [7:0] over_temp,
  input  wire logic [7:0] over_current,
  // supply monitors
  input  wire logic       logic_supply_uv,
  input  wire logic       load_supply_uv,
  // driver controls
  output logic      [7:0] gate_on,
  output logic      [7:0] detect_src_en,
  // status
  output logic      [7:0] fault_status_reg,
  output logic            load_status_suspect
);
  localparam logic [osfl_pkg::TIMER_W-1:0] FILT_LIM =
    osfl_pkg::TIMER_W'(FILTER_CYCLES - 1);

  logic [osfl_pkg::SYNC_W-1:0] raw;
  logic [osfl_pkg::SYNC_W-1:0] syn;
  logic                        cs_n_s;
  logic                        sclk_s;
  logic                        si_s;
  logic [7:0]                  ol_s;
  logic [7:0]                  ot_s;
  logic [7:0]                  oc_s;
  logic                        uv_s;
  logic                        puv_s;
  logic [7:0]                  rx_word;
  logic                        frame_start;
  logic                        frame_end;
  logic                        frame_full;
  logic [7:0]                  cmd_q;
  logic [7:0]                  therm_q;
  logic [7:0]                  gate_q;
  logic [7:0]                  src_q;
  logic [7:0]                  fault_q;
  logic [7:0]                  reported_q;
  logic                        suspect_q;
  logic [osfl_pkg::TIMER_W-1:0] timer_q;
  osfl_pkg::osfl_filt_t        filt_q;
  logic                        filt_done;
  logic [7:0]                  ol_set;
  logic [7:0]                  short_set;
  logic [7:0]                  fault_clr;

  // every pin level crosses two flops before use
  // select enters inverted so the cleared synchroniser reads idle, no false frame
  assign raw = {load_supply_uv, logic_supply_uv, over_current, over_temp,
                ol_below_threshold, spi_si, spi_sclk, ~spi_cs_n};

  osfl_sync #(
    .W (osfl_pkg::SYNC_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .d       (raw),
    .q       (syn)
  );

  assign cs_n_s = !syn[osfl_pkg::SY_CS];
  assign sclk_s = syn[osfl_pkg::SY_SCLK];
  assign si_s   = syn[osfl_pkg::SY_SI];
  assign ol_s   = syn[osfl_pkg::SY_OL +: 8]; // [R06]
  assign ot_s   = syn[osfl_pkg::SY_OT +: 8];
  assign oc_s   = syn[osfl_pkg::SY_OC +: 8];
  assign uv_s   = syn[osfl_pkg::SY_LUV];
  assign puv_s  = syn[osfl_pkg::SY_PUV];

  // the link restarts from scratch under logic undervoltage
  osfl_shift u_shift (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .clear       (uv_s),
    .cs_n_s      (cs_n_s),
    .sclk_s      (sclk_s),
    .si_s        (si_s),
    .tx_word     (fault_q),
    .rx_word     (rx_word),
    .so_q        (spi_so),
    .so_oe_q     (spi_so_oe),
    .frame_start (frame_start),
    .frame_end   (frame_end),
    .frame_full  (frame_full)
  ); // [R01]

  // command byte, bit n drives channel n+1
  always_ff @(posedge sys_clk) begin
    if (!nrst || uv_s) begin
      cmd_q <= osfl_pkg::CMD_RST; // [R16]
    end else if (frame_end) begin
      cmd_q <= rx_word; // [R03] [R02]
    end
  end

  // thermal shutdown follows the sensor, so cooling retries on its own
  always_ff @(posedge sys_clk) begin
    if (!nrst || uv_s) begin
      therm_q <= 8'h00;
    end else begin
      therm_q <= cmd_q & ot_s; // [R13] [R14] [R15]
    end
  end

  // load supply level deliberately not used here
  always_ff @(posedge sys_clk) begin
    if (!nrst || uv_s) begin
      gate_q <= 8'h00; // [R16]
    end else begin
      gate_q <= cmd_q & ~therm_q; // [R18] [R13]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst || uv_s) begin
      src_q <= 8'h00; // [R12]
    end else begin
      src_q <= 8'hFF;
    end
  end

  // fault filter timer
  always_ff @(posedge sys_clk) begin
    if (!nrst || uv_s || frame_end) begin
      timer_q <= '0; // [R09]
      filt_q  <= osfl_pkg::FILT_BLANK;
    end else begin
      case (filt_q)
        osfl_pkg::FILT_BLANK: begin
          timer_q <= timer_q + 1'b1;
          if (timer_q == FILT_LIM) begin
            filt_q <= osfl_pkg::FILT_ARMED; // [R08]
          end
        end
        osfl_pkg::FILT_ARMED: begin
          timer_q <= timer_q;
        end
        default: begin
          timer_q <= '0;
          filt_q  <= osfl_pkg::FILT_BLANK;
        end
      endcase
    end
  end

  assign filt_done = (filt_q == osfl_pkg::FILT_ARMED);

  // open load only on off channels, only after the filter
  assign ol_set    = filt_done ? (ol_s & ~cmd_q) : 8'h00; // [R05] [R07] [R10]
  assign short_set = (gate_q & oc_s) | (cmd_q & ot_s);
  // a bit clears only once a full frame carried it out
  assign fault_clr = (frame_end && frame_full) ? reported_q : 8'h00; // [R20]

  always_ff @(posedge sys_clk) begin
    if (!nrst || uv_s) begin
      reported_q <= 8'h00;
    end else if (frame_start) begin
      reported_q <= fault_q;
    end
  end

  // set wins over the readout clear
  always_ff @(posedge sys_clk) begin
    if (!nrst || uv_s) begin
      fault_q <= osfl_pkg::FAULT_RST; // [R16]
    end else begin
      fault_q <= (fault_q & ~fault_clr) | ol_set | short_set; // [R11] [R17] [R02]
    end
  end

  // controller should distrust faults while this is high
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      suspect_q <= 1'b0;
    end else begin
      suspect_q <= puv_s; // [R19]
    end
  end

  assign gate_on             = gate_q;
  assign detect_src_en       = src_q;
  assign fault_status_reg    = fault_q;
  assign load_status_suspect = suspect_q;

  // assertions
  cmd_update_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R03]
    frame_end && !uv_s |=> cmd_q == $past(rx_word))
    else $error("command byte not applied at frame end");

  timer_restart_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R09]
    frame_end |=> !filt_done && timer_q == '0)
    else $error("filter timer not restarted");

  filter_length_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R08]
    $rose(filt_done) |-> $past(timer_q) == FILT_LIM)
    else $error("filter delay has wrong length");

  blank_ignore_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
    !filt_done && !uv_s |=> (fault_q & ~$past(fault_q) & ~$past(cmd_q)) == 8'h00)
    else $error("open load flagged during blanking");

  ol_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
    filt_done && !uv_s |=> (fault_q & $past(ol_s & ~cmd_q)) == $past(ol_s & ~cmd_q))
    else $error("open load not latched");

  ol_on_ignored_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R05]
    !uv_s && short_set == 8'h00 && fault_clr == 8'h00
    |=> (fault_q & ~$past(fault_q) & $past(cmd_q)) == 8'h00)
    else $error("open load flagged on channel commanded on");

  uv_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R16]
    uv_s |=> gate_on == 8'h00 && fault_q == 8'h00 && cmd_q == 8'h00)
    else $error("undervoltage did not clear outputs and faults");

  src_off_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
    uv_s ##1 uv_s |-> detect_src_en == 8'h00)
    else $error("detect current left on without logic supply");

  thermal_retry_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R14]
    !$past(uv_s) && !$past(uv_s, 2)
    |-> gate_on == ($past(cmd_q) & ~($past(cmd_q, 2) & $past(ot_s, 2))))
    else $error("thermal shutdown or retry wrong");

  readout_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R20]
    frame_end && frame_full && !uv_s
    |=> (fault_q & $past(reported_q & ~ol_set & ~short_set)) == 8'h00)
    else $error("reported fault not released");

  hold_fault_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R20]
    !uv_s && !frame_end |=> (fault_q & $past(fault_q)) == $past(fault_q))
    else $error("latched fault dropped before readout");

  frame_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    frame_end && frame_full);
  ol_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    $rose(filt_done) ##[1:20] (ol_set != 8'h00));
  thermal_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    (therm_q != 8'h00) ##[1:50] (therm_q == 8'h00 && gate_on != 8'h00));
  uv_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    (fault_q != 8'h00) ##1 uv_s);
endmodule : osfl_top

// ### osfl_spi_master.sv
// serial link controller model driving the switch, mode 0
module osfl_spi_master (
  // link pins
  output logic       spi_cs_n,
  output logic       spi_sclk,
  output logic       spi_si,
  input  wire logic  spi_so,
  input  wire logic  spi_so_oe,
  // last word read back
  output logic [7:0] rx,
  output logic       done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si   = 1'b0;
    rx       = 8'h00;
    done     = 1'b0;
  end
  // one frame; sclk stands still outside it, 320 ns period
  task automatic xfer(input logic [7:0] cmd);
    logic [7:0] r;
    spi_cs_n = 1'b0;
    #320;
    for (int i = 7; i >= 0; i--) begin
      spi_si = cmd[i];
      #160;
      r[i] = spi_so_oe ? spi_so : 1'bx;
      spi_sclk = 1'b1;
      #160;
      spi_sclk = 1'b0;
    end
    // si no longer meaningful: show the inverse, not the last bit
    spi_si = ~spi_si;
    #160;
    spi_cs_n = 1'b1;
    rx = r;
    done = 1'b1;
    #40;
    done = 1'b0;
  endtask : xfer
endmodule : osfl_spi_master

// ### osfl_top_tb.sv
// self-checking bench for the octal switch fault logic
module osfl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned FILT = 20;
  logic       sys_clk, nrst, spi_cs_n, spi_sclk, spi_si, spi_so, spi_so_oe;
  logic       logic_supply_uv, load_supply_uv, load_status_suspect, done;
  logic [7:0] ol_below_threshold, over_temp, over_current, gate_on;
  logic [7:0] detect_src_en, fault_status_reg, rx, cmd1, cmd2, ol, hot;
  logic [7:0] exp_q[$];
  int         n_errors, cmp_count, seed;
  osfl_top #(.FILTER_CYCLES(FILT)) uut (
    .sys_clk(sys_clk), .nrst(nrst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
    .ol_below_threshold(ol_below_threshold), .over_temp(over_temp),
    .over_current(over_current), .logic_supply_uv(logic_supply_uv),
    .load_supply_uv(load_supply_uv), .gate_on(gate_on), .detect_src_en(detect_src_en),
    .fault_status_reg(fault_status_reg), .load_status_suspect(load_status_suspect));
  osfl_spi_master mst (
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .rx(rx), .done(done));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // controller keeps the write gap before every frame
  task automatic frame(input logic [7:0] cmd, input logic [7:0] exp);
    step(osfl_pkg::CMD_GAP_CYC + 1);
    exp_q.push_back(exp);
    mst.xfer(cmd);
  endtask : frame
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // read-back words are judged here, oldest note first
  initial begin
    forever begin
      @(posedge done);
      cmp_count++;
      if (exp_q.size() == 0 || rx !== exp_q[0]) begin
        n_errors++;
        $display("CHECK FAILED fault word expected %h seen %h",
                 exp_q.size() ? exp_q[0] : 8'hxx, rx);
      end
      if (exp_q.size()) void'(exp_q.pop_front());
    end
  end
  initial begin
    #3_600_000;
    n_errors++;
    $display("CHECK FAILED watchdog expected done seen hang");
    print_verdict();
  end
  initial begin
    seed = 5050;
    nrst = 1'b0;
    ol_below_threshold = 8'h00;
    over_temp = 8'h00;
    over_current = 8'h00;
    logic_supply_uv = 1'b0;
    load_supply_uv = 1'b0;
    step(2);
    nrst = 1'b1;
    step(3);
    check("detect_src_en", 8'hFF, detect_src_en);
    cmd1 = 8'($random(seed));
    cmd2 = 8'($random(seed));
    ol = 8'($random(seed));
    hot = 8'h01 << ($unsigned($random(seed)) % 8);
    frame(cmd1, 8'h00);
    check("gate_on before apply", 8'h00, gate_on);
    step(8);
    check("gate_on", cmd1, gate_on);
    // open load only on channels commanded off, after the filter
    ol_below_threshold = ol;
    frame(cmd2, ol & ~cmd1);
    // bits still seen at the closing edge latch again: set beats readout clear
    step(10);
    check("fault blanked", ol & ~cmd1, fault_status_reg);
    step(30);
    check("fault armed", ol & ~(cmd1 & cmd2), fault_status_reg);
    ol_below_threshold = 8'h00;
    frame(cmd2, ol & ~(cmd1 & cmd2));
    frame(8'hFF, 8'h00);
    step(8);
    // thermal retry twice on one channel, the rest untouched
    for (int k = 0; k < 2; k++) begin
      over_temp = hot;
      step(6);
      check("gate_on hot", 8'hFF & ~hot, gate_on);
      over_temp = 8'h00;
      step(6);
      check("gate_on cooled", 8'hFF, gate_on);
    end
    load_supply_uv = 1'b1;
    step(6);
    check("suspect", 8'h01, {7'h00, load_status_suspect});
    check("gate_on load uv", 8'hFF, gate_on);
    load_supply_uv = 1'b0;
    frame(8'h0F, hot);
    ol_below_threshold = 8'hFF;
    step(40);
    check("fault before uv", 8'hF0, fault_status_reg);
    check("gate_on before uv", 8'h0F, gate_on);
    // overcurrent only counts on channels whose gate is on
    over_current = 8'h3C;
    step(6);
    check("fault short", 8'hFC, fault_status_reg);
    over_current = 8'h00;
    logic_supply_uv = 1'b1;
    step(6);
    check("gate_on uv", 8'h00, gate_on);
    check("fault uv", 8'h00, fault_status_reg);
    check("detect_src_en uv", 8'h00, detect_src_en);
    logic_supply_uv = 1'b0;
    step(6);
    check("detect_src_en back", 8'hFF, detect_src_en);
    step(40);
    check("fault resumed", 8'hFF, fault_status_reg);
    frame(8'h00, 8'hFF);
    step(4);
    print_verdict();
  end
endmodule : osfl_top_tb
